/* logic/drive_defines.svh */
// Offsets, field positions, masks and reset values of the drive select bank.
// Assumes an 8-bit register port with a 3-bit address.
`ifndef DRIVE_DEFINES_SVH
`define DRIVE_DEFINES_SVH

// ==========================================================
// Register offsets
`define SRC_SEL_0_OFFSET 3'h0
`define SRC_SEL_1_OFFSET 3'h1
`define SINK_A_OFFSET 3'h2
`define SINK_C_OFFSET 3'h3
`define SINK_D_OFFSET 3'h4

// ==========================================================
// Source field positions (two bits each)
`define PORTA_LOW_SRC_LSB 0
`define PORTA_HIGH_SRC_LSB 2
`define PORTB_LOW_SRC_LSB 4
`define PORTB_HIGH_SRC_LSB 6
`define PORTC_LOW_SRC_LSB 0
`define PORTC_HIGH_SRC_LSB 2
`define PORTD_SRC_LSB 4

// ==========================================================
// Implemented bit masks
`define SRC_SEL_0_MASK 8'hFF
`define SRC_SEL_1_MASK 8'h3F
`define SINK_A_MASK 8'hFF
`define SINK_C_MASK 8'hFF
`define SINK_D_MASK 8'h03

// ==========================================================
// Reset values
`define SRC_SEL_0_RESET 8'h00
`define SRC_SEL_1_RESET 8'h00
`define SINK_A_RESET 8'h00
`define SINK_C_RESET 8'h00
`define SINK_D_RESET 8'h00
`define UNMAPPED_READ 8'h00

`endif

/* logic/drive_pkg.sv */
// Types shared by the drive select bank and its pin cells.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package drive_pkg;

	// Two-bit source level code, 0 is weakest
	typedef logic [1:0] source_code_type;

	// What one pad driver receives
	typedef struct packed {
		logic output_active;
		source_code_type source_level;
		logic sink_level;
	} pad_drive_type;

endpackage

`default_nettype wire

/* logic/drive_field_register.sv */
// One software register of the drive bank with a mask of implemented bits.
// Assumes a synchronous active-high reset and a one-cycle write strobe.
`default_nettype none

module drive_field_register #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] IMPL_MASK = 8'hFF,
	parameter logic [WIDTH-1:0] RESET_VALUE = 8'h00
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic wr_en_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output var logic [WIDTH-1:0] value_out
);

	// ==========================================================
	// Storage
	logic [WIDTH-1:0] value_reg;

	// Unimplemented bits never store anything
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			value_reg <= RESET_VALUE & IMPL_MASK;
		end else if (wr_en_in) begin
			value_reg <= wr_data_in & IMPL_MASK;
		end
	end

	assign value_out = value_reg;

endmodule

`default_nettype wire

/* logic/pin_drive_cell.sv */
// Drive code for one pad, gated by the pin's direction bit.
// Assumes direction 0 means CMOS output, 1 means input.
`default_nettype none

module pin_drive_cell #(
	parameter bit HAS_SINK = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire drive_pkg::source_code_type source_code_in,
	input wire logic sink_bit_in,
	input wire logic dir_bit_in,
	output var drive_pkg::pad_drive_type drive_out
);

	// ==========================================================
	// Gating
	drive_pkg::pad_drive_type drive_next;
	drive_pkg::pad_drive_type drive_reg;

	// Settings reach the pad only while it is a CMOS output
	always_comb begin
		drive_next = '0;
		if (!dir_bit_in) begin // R8 R12 R14
			drive_next.output_active = 1'b1;
			drive_next.source_level = source_code_in; // R1
			drive_next.sink_level = HAS_SINK ? sink_bit_in : 1'b0; // R7
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign drive_out = drive_reg;

endmodule

`default_nettype wire

/* logic/io_drive_strength_select.sv */
// Drive strength select bank: source fields, sink bits, gated pad codes.
// Assumes a simple register port on ref_clk_in and direction bits from the ports.
//
// What this block does
// [R1] Source field codes 00..11 select levels 0 (min) to 3 (max).
// [R2] Bits 1..0 of source select 0 drive port A pins 3..0.
// [R3] Bits 7..6 of source select 1 read zero, writes ignored.
// [R4] Bits 5..4 of source select 1 drive port D pins 1..0.
// [R5] Source select 1 bits 3..2 drive port C 7..4, bits 1..0 port C 3..0.
// [R6] Sink selection exists for ports A, C, D only, never port B.
// [R7] Sink bit 0 selects minimum level, 1 selects maximum level.
// [R8] Sink bit affects the pad only while the pin is a CMOS output.
// [R9] Port A sink bit n controls port A pin n.
// [R10] All drive settings clear to zero on reset.
// [R11] Source select 0 bits 7..6 port B 7..4, 5..4 B 3..0, 3..2 A 7..4.
// [R12] Source fields affect the pad only while the pin is a CMOS output.
// [R13] Port C sink bit n controls port C pin n.
// [R14] Direction bit 0 means CMOS output, 1 means input.
`default_nettype none

`include "drive_defines.svh"

module io_drive_strength_select #(
	parameter int ADDR_W = 3,
	parameter int DATA_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output var logic [DATA_W-1:0] rd_data_out,
	input wire logic [7:0] dir_a_in,
	input wire logic [7:0] dir_b_in,
	input wire logic [7:0] dir_c_in,
	input wire logic [1:0] dir_d_in,
	output var drive_pkg::pad_drive_type [7:0] port_a_drive_out,
	output var drive_pkg::pad_drive_type [7:0] port_b_drive_out,
	output var drive_pkg::pad_drive_type [7:0] port_c_drive_out,
	output var drive_pkg::pad_drive_type [1:0] port_d_drive_out
);

	// ==========================================================
	// Elaboration checks
	if (ADDR_W != 3) begin : g_bad_addr
		$error("ADDR_W must be 3");
	end
	if (DATA_W != 8) begin : g_bad_data
		$error("DATA_W must be 8");
	end

	// ==========================================================
	// Address decode
	logic wr_src0;
	logic wr_src1;
	logic wr_sink_a;
	logic wr_sink_c;
	logic wr_sink_d;

	assign wr_src0 = wr_in && (addr_in == `SRC_SEL_0_OFFSET);
	assign wr_src1 = wr_in && (addr_in == `SRC_SEL_1_OFFSET);
	assign wr_sink_a = wr_in && (addr_in == `SINK_A_OFFSET);
	assign wr_sink_c = wr_in && (addr_in == `SINK_C_OFFSET);
	assign wr_sink_d = wr_in && (addr_in == `SINK_D_OFFSET);

	// ==========================================================
	// Registers
	logic [7:0] source_drive_select_0;
	logic [7:0] source_drive_select_1;
	logic [7:0] port_a_sink_select;
	logic [7:0] port_c_sink_select;
	logic [7:0] port_d_sink_select;

	drive_field_register #(
		.WIDTH(8),
		.IMPL_MASK(`SRC_SEL_0_MASK),
		.RESET_VALUE(`SRC_SEL_0_RESET)
	) u_source_drive_select_0 (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_src0),
		.wr_data_in(wr_data_in),
		.value_out(source_drive_select_0)
	); // R10

	// Top two bits unimplemented
	drive_field_register #(
		.WIDTH(8),
		.IMPL_MASK(`SRC_SEL_1_MASK),
		.RESET_VALUE(`SRC_SEL_1_RESET)
	) u_source_drive_select_1 (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_src1),
		.wr_data_in(wr_data_in),
		.value_out(source_drive_select_1)
	); // R3

	drive_field_register #(
		.WIDTH(8),
		.IMPL_MASK(`SINK_A_MASK),
		.RESET_VALUE(`SINK_A_RESET)
	) u_port_a_sink_select (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_sink_a),
		.wr_data_in(wr_data_in),
		.value_out(port_a_sink_select)
	);

	drive_field_register #(
		.WIDTH(8),
		.IMPL_MASK(`SINK_C_MASK),
		.RESET_VALUE(`SINK_C_RESET)
	) u_port_c_sink_select (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_sink_c),
		.wr_data_in(wr_data_in),
		.value_out(port_c_sink_select)
	);

	// Only two pins on port D
	drive_field_register #(
		.WIDTH(8),
		.IMPL_MASK(`SINK_D_MASK),
		.RESET_VALUE(`SINK_D_RESET)
	) u_port_d_sink_select (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_sink_d),
		.wr_data_in(wr_data_in),
		.value_out(port_d_sink_select)
	);

	// ==========================================================
	// Read path
	logic [7:0] rd_data_next;
	logic [7:0] rd_data_reg;

	always_comb begin
		case (addr_in)
			`SRC_SEL_0_OFFSET: rd_data_next = source_drive_select_0;
			`SRC_SEL_1_OFFSET: rd_data_next = source_drive_select_1; // R3
			`SINK_A_OFFSET: rd_data_next = port_a_sink_select;
			`SINK_C_OFFSET: rd_data_next = port_c_sink_select;
			`SINK_D_OFFSET: rd_data_next = port_d_sink_select;
			default: rd_data_next = `UNMAPPED_READ;
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rd_data_reg <= 8'h00;
		end else if (rd_in) begin
			rd_data_reg <= rd_data_next;
		end else begin
			rd_data_reg <= 8'h00;
		end
	end

	assign rd_data_out = rd_data_reg;

	// ==========================================================
	// Pad drive cells
	for (genvar i = 0; i < 8; i++) begin : g_port_a
		pin_drive_cell #(
			.HAS_SINK(1'b1)
		) u_cell (
			.ref_clk_in(ref_clk_in),
			.reset_in(reset_in),
			.source_code_in((i < 4) ?
				source_drive_select_0[`PORTA_LOW_SRC_LSB +: 2] :
				source_drive_select_0[`PORTA_HIGH_SRC_LSB +: 2]), // R2 R11
			.sink_bit_in(port_a_sink_select[i]), // R9
			.dir_bit_in(dir_a_in[i]), // R14
			.drive_out(port_a_drive_out[i])
		);
	end

	for (genvar i = 0; i < 8; i++) begin : g_port_b
		pin_drive_cell #(
			.HAS_SINK(1'b0)
		) u_cell (
			.ref_clk_in(ref_clk_in),
			.reset_in(reset_in),
			.source_code_in((i < 4) ?
				source_drive_select_0[`PORTB_LOW_SRC_LSB +: 2] :
				source_drive_select_0[`PORTB_HIGH_SRC_LSB +: 2]), // R11
			.sink_bit_in(1'b0), // R6
			.dir_bit_in(dir_b_in[i]),
			.drive_out(port_b_drive_out[i])
		);
	end

	for (genvar i = 0; i < 8; i++) begin : g_port_c
		pin_drive_cell #(
			.HAS_SINK(1'b1)
		) u_cell (
			.ref_clk_in(ref_clk_in),
			.reset_in(reset_in),
			.source_code_in((i < 4) ?
				source_drive_select_1[`PORTC_LOW_SRC_LSB +: 2] :
				source_drive_select_1[`PORTC_HIGH_SRC_LSB +: 2]), // R5
			.sink_bit_in(port_c_sink_select[i]), // R13
			.dir_bit_in(dir_c_in[i]),
			.drive_out(port_c_drive_out[i])
		);
	end

	for (genvar i = 0; i < 2; i++) begin : g_port_d
		pin_drive_cell #(
			.HAS_SINK(1'b1)
		) u_cell (
			.ref_clk_in(ref_clk_in),
			.reset_in(reset_in),
			.source_code_in(source_drive_select_1[`PORTD_SRC_LSB +: 2]), // R4
			.sink_bit_in(port_d_sink_select[i]),
			.dir_bit_in(dir_d_in[i]),
			.drive_out(port_d_drive_out[i])
		);
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	logic [7:0] port_b_sink_bits;
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			port_b_sink_bits[k] = port_b_drive_out[k].sink_level;
		end
	end

	sequence s_write_src1;
		wr_in && (addr_in == `SRC_SEL_1_OFFSET);
	endsequence

	sequence s_read_src1;
		rd_in && (addr_in == `SRC_SEL_1_OFFSET);
	endsequence

	sequence s_write_sink_a;
		wr_in && (addr_in == `SINK_A_OFFSET) && !dir_a_in[4];
	endsequence

	// Pads read zero in the cycle after reset
	logic reset_seen_reg;
	always_ff @(posedge ref_clk_in) begin
		reset_seen_reg <= reset_in;
	end

	a_src_a_low: assert property ( // R2
		port_a_drive_out[1].source_level ==
		((reset_seen_reg || $past(dir_a_in[1])) ? 2'h0 :
		$past(source_drive_select_0[1:0])))
		else $error("port A low source level wrong");

	a_src_level_max: assert property ( // R1
		(wr_in && (addr_in == `SRC_SEL_0_OFFSET) && (wr_data_in[1:0] == 2'h3))
		##1 (!dir_a_in[0] && !wr_src0) |=> (port_a_drive_out[0].source_level == 2'h3))
		else $error("code 11 did not give the maximum level");

	a_src_shared_map: assert property ( // R11
		(port_a_drive_out[6].source_level ==
		((reset_seen_reg || $past(dir_a_in[6])) ? 2'h0 :
		$past(source_drive_select_0[3:2]))) &&
		(port_b_drive_out[2].source_level ==
		((reset_seen_reg || $past(dir_b_in[2])) ? 2'h0 :
		$past(source_drive_select_0[5:4]))) &&
		(port_b_drive_out[7].source_level ==
		((reset_seen_reg || $past(dir_b_in[7])) ? 2'h0 :
		$past(source_drive_select_0[7:6]))))
		else $error("source select 0 field mapping wrong");

	a_src1_unimpl: assert property ( // R3
		s_write_src1 ##1 s_read_src1 |=>
		(rd_data_out == ($past(wr_data_in, 2) & `SRC_SEL_1_MASK)))
		else $error("source select 1 upper bits not zero");

	a_src_port_d: assert property ( // R4
		port_d_drive_out[1].source_level ==
		((reset_seen_reg || $past(dir_d_in[1])) ? 2'h0 :
		$past(source_drive_select_1[5:4])))
		else $error("port D source level wrong");

	a_src_port_c: assert property ( // R5
		(port_c_drive_out[2].source_level ==
		((reset_seen_reg || $past(dir_c_in[2])) ? 2'h0 :
		$past(source_drive_select_1[1:0]))) &&
		(port_c_drive_out[5].source_level ==
		((reset_seen_reg || $past(dir_c_in[5])) ? 2'h0 :
		$past(source_drive_select_1[3:2]))))
		else $error("port C source level wrong");

	a_sink_port_b: assert property ( // R6
		port_b_sink_bits == 8'h00)
		else $error("port B shows a sink level");

	a_sink_a_write: assert property ( // R7
		s_write_sink_a ##1 (!dir_a_in[4] && !wr_sink_a) |=>
		(port_a_drive_out[4].sink_level == $past(wr_data_in[4], 2)))
		else $error("port A sink bit not applied");

	a_input_idle: assert property ( // R8
		$past(dir_c_in[4]) |-> (port_c_drive_out[4] == '0))
		else $error("input pin received drive settings");

	a_sink_a_map: assert property ( // R9
		port_a_drive_out[4].sink_level ==
		(!reset_seen_reg && !$past(dir_a_in[4]) && $past(port_a_sink_select[4])))
		else $error("port A sink bit mapping wrong");

	a_pads_reset: assert property ( // R10
		reset_seen_reg |-> ((port_a_drive_out == '0) && (port_b_drive_out == '0) &&
		(port_c_drive_out == '0) && (port_d_drive_out == '0)))
		else $error("pad codes not cleared by reset");

	a_reset_clear: assert property ( // R10
		@(posedge ref_clk_in) disable iff (1'b0)
		reset_in |=> ((source_drive_select_0 == `SRC_SEL_0_RESET) &&
		(source_drive_select_1 == `SRC_SEL_1_RESET) &&
		(port_a_sink_select == `SINK_A_RESET) &&
		(port_c_sink_select == `SINK_C_RESET) &&
		(port_d_sink_select == `SINK_D_RESET)))
		else $error("settings not cleared by reset");

	a_src_gate_b: assert property ( // R12
		$past(dir_b_in[0]) |-> (port_b_drive_out[0].source_level == 2'h0))
		else $error("source level leaked to an input pin");

	a_sink_c_map: assert property ( // R13
		port_c_drive_out[7].sink_level ==
		(!reset_seen_reg && !$past(dir_c_in[7]) && $past(port_c_sink_select[7])))
		else $error("port C sink bit mapping wrong");

	a_sink_d_map: assert property ( // R6
		port_d_drive_out[1].sink_level ==
		(!reset_seen_reg && !$past(dir_d_in[1]) && $past(port_d_sink_select[1])))
		else $error("port D sink bit mapping wrong");

	a_dir_active: assert property ( // R14
		(port_d_drive_out[0].output_active ==
		(!reset_seen_reg && !$past(dir_d_in[0]))) &&
		(port_a_drive_out[7].output_active ==
		(!reset_seen_reg && !$past(dir_a_in[7]))))
		else $error("output active flag disagrees with direction");

endmodule

`default_nettype wire

/* tb/tb_io_drive_strength_select.sv */
// Self-checking bench for the drive strength select bank.
// Assumes the bank's register port, direction inputs and registered pad codes.
`default_nettype none

`include "drive_defines.svh"

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("BAD %s exp %h got %h", what, exp, got); end end

module tb_io_drive_strength_select;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	logic ref_clk;
	logic reset;
	logic wr;
	logic rd;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] dir_c;
	logic [1:0] dir_d;
	drive_pkg::pad_drive_type [7:0] pads_a;
	drive_pkg::pad_drive_type [7:0] pads_b;
	drive_pkg::pad_drive_type [7:0] pads_c;
	drive_pkg::pad_drive_type [1:0] pads_d;
	logic [7:0] m [0:4];
	logic [7:0] mask [0:4];
	logic [7:0] pats [0:3];
	int fails = 0;
	int checks_done = 0;

	io_drive_strength_select dut (
		.ref_clk_in(ref_clk),
		.reset_in(reset),
		.addr_in(addr),
		.wr_data_in(wdata),
		.wr_in(wr),
		.rd_in(rd),
		.rd_data_out(rdata),
		.dir_a_in(dir_a),
		.dir_b_in(dir_b),
		.dir_c_in(dir_c),
		.dir_d_in(dir_d),
		.port_a_drive_out(pads_a),
		.port_b_drive_out(pads_b),
		.port_c_drive_out(pads_c),
		.port_d_drive_out(pads_d)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Helpers
	function automatic drive_pkg::pad_drive_type pad_exp(input logic d, input logic [1:0] s,
		input logic k);
		pad_exp = d ? '0 : {1'b1, s, k};
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		if (a < 3'h5) m[a] = d & mask[a];
		@(posedge ref_clk);
	endtask

	// Data stands only in the cycle after the strobe, then idles at zero
	task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 `CHK("rd_data", exp, rdata)
		@(posedge ref_clk);
		#1 `CHK("rd_idle", 8'h00, rdata)
		@(posedge ref_clk);
	endtask

	// Write then read back with no gap between the strobes
	task automatic wr_rd(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		m[a] = d & mask[a];
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 `CHK("rd_back", m[a], rdata)
		@(posedge ref_clk);
	endtask

	task automatic check_pads();
		int lo;
		@(posedge ref_clk);
		@(posedge ref_clk);
		#1;
		for (int i = 0; i < 8; i++) begin
			lo = (i < 4) ? 0 : 2;
			`CHK("pad_a", pad_exp(dir_a[i], m[0][lo +: 2], m[2][i]), pads_a[i])
			`CHK("pad_b", pad_exp(dir_b[i], m[0][lo + 4 +: 2], 1'b0), pads_b[i])
			`CHK("pad_c", pad_exp(dir_c[i], m[1][lo +: 2], m[3][i]), pads_c[i])
			if (i < 2) `CHK("pad_d", pad_exp(dir_d[i], m[1][5:4], m[4][i]), pads_d[i])
		end
		@(posedge ref_clk);
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#200_000;
		fails++;
		report_and_stop();
	end

	// ==========================================================
	// Tests
	initial begin
		int k;
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		dir_a = 8'h00;
		dir_b = 8'h00;
		dir_c = 8'h00;
		dir_d = 2'h0;
		mask = '{`SRC_SEL_0_MASK, `SRC_SEL_1_MASK, `SINK_A_MASK, `SINK_C_MASK, `SINK_D_MASK};
		pats = '{8'hE4, 8'h39, 8'h4E, 8'h93};
		for (k = 0; k < 5; k++) m[k] = 8'h00;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		for (k = 0; k < 5; k++) check_reg(k[2:0], 8'h00);
		check_pads();
		// Unimplemented bits and unmapped places
		for (k = 0; k < 8; k++) wr_reg(k[2:0], 8'hFF);
		for (k = 0; k < 8; k++) check_reg(k[2:0], (k < 5) ? m[k] : 8'h00);
		wr_rd(3'h1, 8'hC6);
		// Every code in every field, both sink levels
		for (k = 0; k < 4; k++) begin
			wr_reg(3'h0, pats[k]);
			wr_reg(3'h1, pats[k]);
			wr_reg(3'h2, pats[k]);
			wr_reg(3'h3, ~pats[k]);
			wr_reg(3'h4, pats[k]);
			check_pads();
		end
		// Inputs drop drive, contents survive
		dir_a <= 8'hAA;
		dir_b <= 8'h55;
		dir_c <= 8'hF0;
		dir_d <= 2'h2;
		check_pads();
		wr_reg(3'h2, 8'h5A);
		check_reg(3'h2, 8'h5A);
		check_pads();
		dir_a <= 8'h00;
		dir_b <= 8'h00;
		dir_c <= 8'h00;
		dir_d <= 2'h0;
		check_pads();
		// Reset in mid-run
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		for (k = 0; k < 5; k++) m[k] = 8'h00;
		for (k = 0; k < 5; k++) check_reg(k[2:0], 8'h00);
		check_pads();
		report_and_stop();
	end
endmodule

`undef CHK

`default_nettype wire
